// ### verilog/srsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module srsc_top
    import srsc_pkg::*;
#(
    parameter int NUM_DS = srsc_pkg::NUM_DS_PORTS
) (
    // Clock and reset
    input  wire logic                              i_sys_clk,
    input  wire logic                              i_reset_n,
    // Strap pins
    input  wire logic                              i_downstream_common_clock_strap,
    input  wire logic                              i_upstream_common_clock_strap,
    input  wire logic                              i_master_smbus_slow_strap,
    input  wire logic                              i_reset_hold_strap,
    input  wire logic [srsc_pkg::MODE_W-1:0]       i_switch_mode_strap,
    input  wire logic [srsc_pkg::ADDR_STRAP_W-1:0] i_eeprom_address_strap,
    // Slot clock bit writes from the register path
    input  wire logic [NUM_DS-1:0]                 i_ds_sclk_wr,
    input  wire logic [NUM_DS-1:0]                 i_ds_sclk_wdata,
    input  wire logic                              i_us_sclk_wr,
    input  wire logic                              i_us_sclk_wdata,
    // Reset-hold bit clear from an SMBus master
    input  wire logic                              i_hold_clear,
    // EEPROM loader handshake
    input  wire logic                              i_eeprom_done,
    // Outputs
    output logic [NUM_DS-1:0]                      o_ds_slot_clock,
    output logic                                   o_us_slot_clock,
    output logic [9:0]                             o_smbus_clk_div,
    output logic                                   o_smbus_active,
    output logic                                   o_core_reset_n,
    output logic                                   o_switch_run,
    output logic                                   o_reset_hold_bit,
    output logic                                   o_eeprom_start,
    output logic [6:0]                             o_eeprom_addr,
    output logic                                   o_mode_reserved
);
    typedef struct packed {
        logic [NUM_DS-1:0] ds_sclk;
        logic              us_sclk;
        logic              slow;
        logic [MODE_W-1:0] mode;
        logic [6:0]        eaddr;
        logic              hold;
        logic              start;
        srsc_state_t       st;
        logic [9:0]        div;
        logic              core_rst_n;
        logic              run;
        logic              rsvd;
        logic              active;
    } srsc_regs_t;

    srsc_regs_t r_q;
    srsc_regs_t r_d;
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [MODE_W+ADDR_STRAP_W+3:0] straps_raw;
    logic [MODE_W+ADDR_STRAP_W+3:0] straps_s;
    logic       ds_cc_s;
    logic       us_cc_s;
    logic       slow_s;
    logic       hold_s;
    logic [MODE_W-1:0] mode_s;
    logic [ADDR_STRAP_W-1:0] addr_s;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign straps_raw = {i_downstream_common_clock_strap, i_upstream_common_clock_strap,
                         i_master_smbus_slow_strap, i_reset_hold_strap, i_switch_mode_strap,
                         i_eeprom_address_strap};

    srsc_strap_sync #(
        .WIDTH ($bits(straps_raw))
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_reset_n),
        .i_async   (straps_raw),
        .o_sync    (straps_s)
    );

    assign addr_s  = straps_s[ADDR_STRAP_W-1:0];
    assign mode_s  = straps_s[ADDR_STRAP_W +: MODE_W];
    assign hold_s  = straps_s[ADDR_STRAP_W+MODE_W];
    assign slow_s  = straps_s[ADDR_STRAP_W+MODE_W+1];
    assign us_cc_s = straps_s[ADDR_STRAP_W+MODE_W+2];
    assign ds_cc_s = straps_s[ADDR_STRAP_W+MODE_W+3];

    always_comb begin
        r_d       = r_q;
        r_d.start = 1'b0;
        unique case (r_q.st)
            SRSC_ST_RESET: begin
                r_d.slow = slow_s;
                r_d.mode = mode_s;
                r_d.eaddr = {EEPROM_BASE_ADDR[6:4], addr_s};
                r_d.hold = hold_s;
                r_d.rsvd = (mode_s != MODE_NORMAL) && (mode_s != MODE_EEPROM_INIT);
                r_d.ds_sclk = {NUM_DS{ds_cc_s}};
                r_d.us_sclk = us_cc_s;
                r_d.div = slow_s ? SMB_SLOW_DIV : SMB_FAST_DIV;
                r_d.st = hold_s ? SRSC_ST_HOLD : SRSC_ST_LOAD;
            end
            SRSC_ST_HOLD: begin
                if (i_hold_clear) begin
                    r_d.hold = 1'b0;
                    r_d.st   = SRSC_ST_LOAD;
                end
            end
            SRSC_ST_LOAD: begin
                if (r_q.mode == MODE_EEPROM_INIT) begin
                    r_d.start = 1'b1;
                    r_d.st    = SRSC_ST_RSVD;
                end else begin
                    r_d.st = SRSC_ST_RUN;
                end
            end
            SRSC_ST_RSVD: begin
                if (i_eeprom_done) begin
                    r_d.st = SRSC_ST_RUN;
                end
            end
            SRSC_ST_RUN: begin
                r_d.st = SRSC_ST_RUN;
            end
            default: begin
                r_d.st = SRSC_ST_RESET;
            end
        endcase
        for (int i = 0; i < NUM_DS; i++) begin
            if (i_ds_sclk_wr[i] && r_q.st != SRSC_ST_RESET) begin
                r_d.ds_sclk[i] = i_ds_sclk_wdata[i];
            end
        end
        if (i_us_sclk_wr && r_q.st != SRSC_ST_RESET) begin
            r_d.us_sclk = i_us_sclk_wdata;
        end
        r_d.run        = (r_d.st == SRSC_ST_RUN);
        r_d.core_rst_n = (r_d.st == SRSC_ST_RUN) || (r_d.st == SRSC_ST_RSVD);
        r_d.active     = (r_d.st != SRSC_ST_RESET);
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_ds_slot_clock  = r_q.ds_sclk;
    assign o_us_slot_clock  = r_q.us_sclk;
    assign o_smbus_clk_div  = r_q.div;
    assign o_smbus_active   = r_q.active;
    assign o_core_reset_n   = r_q.core_rst_n;
    assign o_switch_run     = r_q.run;
    assign o_reset_hold_bit = r_q.hold;
    assign o_eeprom_start   = r_q.start;
    assign o_eeprom_addr    = r_q.eaddr;
    assign o_mode_reserved  = r_q.rsvd;

    property p_hold_stays;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st == SRSC_ST_HOLD && !i_hold_clear) |=> (r_q.st == SRSC_ST_HOLD);
    endproperty
    a_hold_stays: assert property (p_hold_stays) else $error("left hold without clear");

    property p_hold_no_run;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st == SRSC_ST_HOLD) |-> !o_switch_run && !o_core_reset_n;
    endproperty
    a_hold_no_run: assert property (p_hold_no_run) else $error("running while held");

    property p_speed;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st != SRSC_ST_RESET) |-> (o_smbus_clk_div == (r_q.slow ? SMB_SLOW_DIV : SMB_FAST_DIV));
    endproperty
    a_speed: assert property (p_speed) else $error("wrong smbus speed");

    property p_strap_stable;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st != SRSC_ST_RESET) |=> $stable(r_q.mode) && $stable(r_q.slow);
    endproperty
    a_strap_stable: assert property (p_strap_stable) else $error("strap copy changed");

    property p_eeprom_first;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st == SRSC_ST_RSVD && !i_eeprom_done) |=> !o_switch_run;
    endproperty
    a_eeprom_first: assert property (p_eeprom_first) else $error("ran before EEPROM load");

    property p_ds_seed;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st == SRSC_ST_RESET) |=> (o_ds_slot_clock == {NUM_DS{$past(ds_cc_s)}});
    endproperty
    a_ds_seed: assert property (p_ds_seed) else $error("downstream seed wrong");

    property p_us_seed;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (r_q.st == SRSC_ST_RESET) |=> (o_us_slot_clock == $past(us_cc_s));
    endproperty
    a_us_seed: assert property (p_us_seed) else $error("upstream seed wrong");

    property p_us_write;
        @(posedge i_sys_clk) disable iff (!rst_n)
        (i_us_sclk_wr && r_q.st != SRSC_ST_RESET) |=> (o_us_slot_clock == $past(i_us_sclk_wdata));
    endproperty
    a_us_write: assert property (p_us_write) else $error("upstream write lost");

    generate
        for (genvar g = 0; g < NUM_DS; g++) begin : g_ds_chk
            property p_ds_write;
                @(posedge i_sys_clk) disable iff (!rst_n)
                (i_ds_sclk_wr[g] && r_q.st != SRSC_ST_RESET) |=> (o_ds_slot_clock[g] == $past(i_ds_sclk_wdata[g]));
            endproperty
            a_ds_write: assert property (p_ds_write) else $error("downstream write lost");
        end
    endgenerate

    sequence s_load_eeprom;
        (r_q.st == SRSC_ST_LOAD) && (r_q.mode == MODE_EEPROM_INIT);
    endsequence

    sequence s_start_wait;
        o_eeprom_start && (r_q.st == SRSC_ST_RSVD) && !o_switch_run && o_core_reset_n;
    endsequence

    property p_eeprom_kick;
        @(posedge i_sys_clk) disable iff (!rst_n)
        s_load_eeprom |=> s_start_wait;
    endproperty
    a_eeprom_kick: assert property (p_eeprom_kick) else $error("EEPROM load not started");
endmodule // srsc_top
`default_nettype wire

// ### verilog/srsc_pkg.sv
`default_nettype none
package srsc_pkg;
    localparam int          NUM_DS_PORTS      = 3;
    localparam int          MODE_W            = 3;
    localparam int          ADDR_STRAP_W      = 4;
    localparam logic [2:0]  MODE_NORMAL       = 3'h0;
    localparam logic [2:0]  MODE_EEPROM_INIT  = 3'h1;
    localparam int          CLK_HZ            = 50000000;
    localparam int          SMB_SLOW_HZ       = 100000;
    localparam int          SMB_FAST_HZ       = 400000;
    localparam logic [9:0]  SMB_SLOW_DIV      = 10'(CLK_HZ / SMB_SLOW_HZ);
    localparam logic [9:0]  SMB_FAST_DIV      = 10'(CLK_HZ / SMB_FAST_HZ);
    localparam logic [6:0]  EEPROM_BASE_ADDR  = 7'h50;
    localparam logic [15:0] EEPROM_TIMEOUT    = 16'hffff;

    typedef enum logic [2:0] {
        SRSC_ST_RESET = 3'b000,
        SRSC_ST_HOLD  = 3'b001,
        SRSC_ST_LOAD  = 3'b010,
        SRSC_ST_RUN   = 3'b011,
        SRSC_ST_RSVD  = 3'b100
    } srsc_state_t;
endpackage
`default_nettype wire

// ### verilog/srsc_strap_sync.sv
`timescale 1ns/100ps
`default_nettype none
module srsc_strap_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Two-stage synchroniser per bit
    generate
        for (genvar g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta_q[g] <= 1'b0;
                    sync_q[g] <= 1'b0;
                end else begin
                    meta_q[g] <= i_async[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign o_sync = sync_q;
endmodule // srsc_strap_sync
`default_nettype wire

// ### verif/srsc_loader_model.sv
`timescale 1ns/100ps
`default_nettype none
module srsc_loader_model (
    // Loader handshake
    input  wire logic       i_sys_clk,
    input  wire logic       i_start,
    input  wire logic [3:0] i_delay,
    output logic            o_done
);
    logic [4:0] cnt_q  = 5'h0;
    logic       done_q = 1'b0;
    assign o_done = done_q;
    always @(posedge i_sys_clk) begin
        done_q <= (cnt_q == 5'h1);
        if (i_start)
            cnt_q <= 5'(i_delay) + 5'h2;
        else if (cnt_q != 5'h0)
            cnt_q <= cnt_q - 5'h1;
    end
endmodule // srsc_loader_model
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import srsc_pkg::*;
    logic       clk = 0, rst_n = 0, ds = 0, us = 0, slow = 0, hold = 0, hclr = 0, usw = 0, usd = 0;
    logic [2:0] mode = 0, dsw = 0, dsd = 0, dsq, rv;
    logic [3:0] addr = 0, dly = 0;
    logic       done, usq, act, crst_n, run, hbit, start, rsvd, st_seen, dn_seen;
    logic [9:0] div;
    logic [6:0] eaddr;
    int         bad_count = 0, total_checks = 0, i, p;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (!rst_n) begin
            st_seen <= 1'b0;
            dn_seen <= 1'b0;
        end else begin
            if (start) st_seen <= 1'b1;
            if (done) dn_seen <= 1'b1;
        end
    end
    srsc_top u_srsc_top (.i_sys_clk(clk), .i_reset_n(rst_n), .i_downstream_common_clock_strap(ds),
        .i_upstream_common_clock_strap(us), .i_master_smbus_slow_strap(slow), .i_reset_hold_strap(hold),
        .i_switch_mode_strap(mode), .i_eeprom_address_strap(addr), .i_ds_sclk_wr(dsw), .i_ds_sclk_wdata(dsd),
        .i_us_sclk_wr(usw), .i_us_sclk_wdata(usd), .i_hold_clear(hclr), .i_eeprom_done(done),
        .o_ds_slot_clock(dsq), .o_us_slot_clock(usq), .o_smbus_clk_div(div), .o_smbus_active(act),
        .o_core_reset_n(crst_n), .o_switch_run(run), .o_reset_hold_bit(hbit), .o_eeprom_start(start),
        .o_eeprom_addr(eaddr), .o_mode_reserved(rsvd));
    srsc_loader_model u_srsc_loader_model (.i_sys_clk(clk), .i_start(start), .i_delay(dly), .o_done(done));
    function automatic logic [9:0] exp_div(input logic s);
        return 10'(50000000 / (s ? 100000 : 400000));
    endfunction
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset();
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic wait_for(input int sel);
        int n;
        for (n = 0; n < 300 && (sel ? hbit : run) !== 1'b1; n++) @(negedge clk);
        if (n == 300) begin
            chk("wait bound", 16'h0, 16'h1);
            close_out();
        end
    endtask
    task automatic pulse_wr(input logic [2:0] w, input logic [2:0] d, input logic uw, input logic ud);
        dsw = w; dsd = d; usw = uw; usd = ud;
        @(negedge clk);
        dsw = 3'h0; usw = 1'b0;
        @(negedge clk);
    endtask
    initial begin
        void'($urandom(17));
        @(negedge clk);
        for (i = 0; i < 10; i++) begin
            rst_n = 1'b0;
            mode = (i < 8) ? 3'(i) : 3'h1;
            {ds, us, slow} = 3'($urandom);
            addr = 4'($urandom);
            dly = (i == 8) ? 4'hf : 4'($urandom);
            do_reset();
            wait_for(0);
            chk("ds slot", {13'h0, {3{ds}}}, {13'h0, dsq});
            chk("us slot", {15'h0, us}, {15'h0, usq});
            chk("divider", {6'h0, exp_div(slow)}, {6'h0, div});
            chk("eeprom addr", {9'h0, EEPROM_BASE_ADDR[6:4], addr}, {9'h0, eaddr});
            chk("reserved", {15'h0, mode > 3'h1}, {15'h0, rsvd});
            chk("start seen", {15'h0, mode == 3'h1}, {15'h0, st_seen});
            chk("done before run", {15'h0, mode == 3'h1}, {15'h0, dn_seen});
            chk("core reset", 16'h1, {15'h0, crst_n});
            {ds, us, slow} = ~{ds, us, slow};
            repeat (6) @(negedge clk);
            chk("strap kept div", {6'h0, exp_div(~slow)}, {6'h0, div});
            chk("strap kept ds", {13'h0, {3{~ds}}}, {13'h0, dsq});
            for (p = 0; p < 3; p++) begin
                rv = 3'($urandom);
                pulse_wr(3'h1 << p, rv, 1'b0, 1'b0);
                chk("ds write", {13'h0, ({3{~ds}} & ~(3'h1 << p)) | (rv & (3'h1 << p))}, {13'h0, dsq});
                pulse_wr(3'h0, 3'h0, 1'b1, rv[0]);
                chk("us write", {15'h0, rv[0]}, {15'h0, usq});
                pulse_wr(3'h7, {3{~ds}}, 1'b0, 1'b0);
            end
            $display("mode test %0d done", i);
        end
        rst_n = 1'b0;
        hold = 1'b1;
        mode = 3'h0;
        do_reset();
        wait_for(1);
        repeat (8) @(negedge clk);
        chk("held smbus", 16'h1, {15'h0, act});
        chk("held core", 16'h0, {15'h0, crst_n});
        chk("held run", 16'h0, {15'h0, run});
        pulse_wr(3'h0, 3'h0, 1'b1, ~usq);
        chk("held write", {15'h0, ~us}, {15'h0, usq});
        hclr = 1'b1;
        @(negedge clk);
        hclr = 1'b0;
        wait_for(0);
        chk("hold bit", 16'h0, {15'h0, hbit});
        $display("hold test done");
        rst_n = 1'b0;
        @(negedge clk);
        chk("reset outs", 16'h0, {run, crst_n, act, hbit, start, dsq, usq, 7'h0});
        $display("reset test done");
        close_out();
    end
endmodule // tb
`default_nettype wire
